// File: rtl/sfc_core.sv
`include "sfc_defines.svh"
`default_nettype none

// How it works
// [R1] Either chip erase opcode alone erases the whole array to ones.
// [R2] Erase starts at chip select rise, runs on a timer, busy shows it.
// [R3] Both program opcodes act alike; low-current one uses a longer timer.
// [R4] Program writes 1 to 256 bytes inside the page given by A19 to A8.
// [R5] Host erases a page before programming it.
// [R6] Host sends opcode, three address bytes, data, then raises select.
// [R7] Whole bytes only; beyond 256 bytes the last 256 are programmed.
// [R8] Pause opcode at select rise halts a running erase or program.
// [R9] After a pause the device refuses commands until it is ready.
// [R10] Pause acts only while an erase or program is running.
// [R11] New erase or program while paused cancels the paused one.
// [R12] While paused, reads and the continue opcode are accepted.
// [R13] A software reset while paused cancels the pause.
// [R14] Continue opcode at select rise resumes the paused cycle with its remaining count; a resumed program writes no bytes, as the pause frame clears them.
// [R15] Continue is ignored once the pause was cancelled.
// [R16] Host waits the continue-to-pause interval before pausing again.
// [R17] Both identity reads are refused while a write runs.
// [R18] Standard identity returns maker, type, capacity, reserved bytes.
// [R19] Device identifier follows three dummy bytes and repeats.
// [R20] Select high ends reads and floats the serial output.
// [R21] Deep power-down entered at select rise, ignored during writes.
// [R22] In deep power-down only the wake opcode is honoured.
// [R23] Wake opcode alone or a full identifier read ends deep power-down.
// [R24] Bits move MSB first, sampled on rising and shifted on falling clock.
// [R25] Short frames are discarded and leave the array unchanged.
module sfc_core
    import sfc_pkg::*;
#(
    parameter int ERASE_CYC = `SFC_ERASE_CYC_DEF,
    parameter int PROG_CYC = `SFC_PROG_CYC_DEF,
    parameter int PROG_LOW_CYC = `SFC_PROG_LOW_CYC_DEF
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    output logic spi_so,
    output logic spi_so_oe,
    output logic busy,
    output logic paused_flag,
    output logic deep_power_down,
    output logic low_current_active,
    output logic array_erase_all,
    output logic array_wr_en,
    output logic [19:0] array_wr_addr,
    output logic [7:0] array_wr_data
);

    localparam logic [`SFC_TIMER_W-1:0] PAUSE_CYC =
        `SFC_TIMER_W'(`SFC_PAUSE_CYC);
    localparam logic [31:0] STD_ID = {`SFC_ID_MAKER, `SFC_ID_TYPE,
        `SFC_ID_CAPACITY, `SFC_ID_RESERVED};
    localparam logic [7:0] DEV_ID = `SFC_ID_DEVICE;

    function automatic logic [`SFC_TIMER_W-1:0] cyc(input int n);
        cyc = `SFC_TIMER_W'(n);
    endfunction : cyc

    function automatic logic is_write_op(input logic [7:0] op);
        is_write_op = (op == `SFC_OP_PROG) || (op == `SFC_OP_PROG_LOW);
    endfunction : is_write_op

    ////////////////////////////////////////////////////////////////////////
    // Link side, clocked by the serial clock; bit counter, sync and permission flags and output cleared by select high.

    sfc_frame_t frame_reg;
    logic [31:0] shift_reg;
    logic [7:0] page_buf [256];
    logic [255:0] buf_valid_reg;
    logic [7:0] buf_ptr_reg;
    logic [15:0] bit_cnt_reg;
    logic over_reg;
    logic std_id_ok_reg, dev_id_ok_reg, prog_ok_reg;
    logic busy_s1_reg, busy_s2_reg, dpd_s1_reg, dpd_s2_reg;
    logic [15:0] bits_next;
    logic [31:0] shift_next;
    logic data_byte_done;
    logic [7:0] id_bit_idx;

    assign bits_next = bit_cnt_reg + 16'h0001;
    assign shift_next = {shift_reg[30:0], spi_si}; // [R24]
    assign data_byte_done = prog_ok_reg && (bits_next[2:0] == 3'h0)
        && (over_reg || bits_next >= `SFC_BITS_DATA_START); // [R7]
    assign id_bit_idx = 8'(`SFC_BITS_STD_ID_END - bit_cnt_reg - 16'h1);

    // Level crossing of busy and deep power-down into the link domain.
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            busy_s1_reg <= 1'b0;
            busy_s2_reg <= 1'b0;
            dpd_s1_reg <= 1'b0;
            dpd_s2_reg <= 1'b0;
        end else begin
            busy_s1_reg <= busy;
            busy_s2_reg <= busy_s1_reg;
            dpd_s1_reg <= deep_power_down;
            dpd_s2_reg <= dpd_s1_reg;
        end
    end

    // Bit counter; select high restarts it for the next frame.
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            bit_cnt_reg <= 16'h0000;
            over_reg <= 1'b0;
        end else begin
            bit_cnt_reg <= bits_next;
            if (bits_next == 16'h0000) begin
                over_reg <= 1'b1;
            end
        end
    end

    // Frame record; it outlives select high so the system side decodes it.
    always_ff @(posedge spi_sck) begin
        shift_reg <= shift_next;
        frame_reg.bits <= bits_next;
        frame_reg.over <= over_reg || bits_next == 16'h0000;
        if (!over_reg && bits_next == `SFC_BITS_OPCODE) begin
            frame_reg.opcode <= shift_next[7:0];
        end
        if (!over_reg && bits_next == `SFC_BITS_ADDR_END) begin
            frame_reg.addr <= shift_next[23:0];
        end
    end

    // Per-frame permissions decided once the opcode is in.
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            std_id_ok_reg <= 1'b0;
            dev_id_ok_reg <= 1'b0;
            prog_ok_reg <= 1'b0;
        end else if (!over_reg && bits_next == `SFC_BITS_OPCODE) begin
            std_id_ok_reg <= shift_next[7:0] == `SFC_OP_STD_ID
                && !busy_s2_reg && !dpd_s2_reg; // [R17] [R22]
            dev_id_ok_reg <= shift_next[7:0] == `SFC_OP_DEV_ID
                && !busy_s2_reg; // [R17] [R23]
            prog_ok_reg <= is_write_op(shift_next[7:0])
                && !busy_s2_reg && !dpd_s2_reg;
        end
    end

    // Page buffer fill; the pointer wraps so the last 256 bytes remain.
    always_ff @(posedge spi_sck) begin
        if (!over_reg && bits_next == `SFC_BITS_OPCODE) begin
            buf_valid_reg <= '0;
        end
        if (!over_reg && bits_next == `SFC_BITS_ADDR_END) begin
            buf_ptr_reg <= shift_next[7:0]; // [R4]
        end
        if (data_byte_done) begin
            page_buf[buf_ptr_reg] <= shift_next[7:0]; // [R7]
            buf_valid_reg[buf_ptr_reg] <= 1'b1;
            buf_ptr_reg <= buf_ptr_reg + 8'h01; // [R4] [R7]
        end
    end

    // Serial output, changed on falling edges, floated when deselected.
    always_ff @(negedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            spi_so <= 1'b0;
            spi_so_oe <= 1'b0; // [R20]
        end else if (std_id_ok_reg && !over_reg
                     && bit_cnt_reg >= `SFC_BITS_OPCODE
                     && bit_cnt_reg < `SFC_BITS_STD_ID_END) begin
            spi_so <= STD_ID[id_bit_idx[4:0]]; // [R18] [R24]
            spi_so_oe <= 1'b1;
        end else if (dev_id_ok_reg && (over_reg
                     || bit_cnt_reg >= `SFC_BITS_DEV_ID_START)) begin
            spi_so <= DEV_ID[3'h7 - bit_cnt_reg[2:0]];
            spi_so_oe <= 1'b1; // [R19]
        end else begin
            spi_so <= 1'b0;
            spi_so_oe <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System side: select edge detection and frame decode.

    logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
    logic frame_end, len_single, len_prog, op_erase, op_prog;
    logic start_job, do_pause, do_continue, do_reset, do_dpd, do_wake;
    logic rst_en_reg, recovering;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
        end else begin
            cs_s1_reg <= spi_cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
        end
    end

    sfc_state_t state_reg;
    sfc_state_t state_next;
    sfc_job_t job_reg;
    logic [`SFC_TIMER_W-1:0] timer_reg;
    logic [`SFC_TIMER_W-1:0] rec_reg;
    logic [7:0] flush_idx_reg;
    logic [11:0] page_reg;

    // The frame is stable once select is high, so fields are read here.
    assign frame_end = cs_s2_reg && !cs_s3_reg;
    assign len_single = !frame_reg.over
        && frame_reg.bits == `SFC_BITS_OPCODE; // [R25]
    assign len_prog = frame_reg.bits[2:0] == 3'h0 && (frame_reg.over
        || frame_reg.bits >= `SFC_BITS_DATA_START); // [R25] [R7]
    assign op_erase = len_single && (frame_reg.opcode == `SFC_OP_ERASE_A
        || frame_reg.opcode == `SFC_OP_ERASE_B); // [R1]
    assign op_prog = len_prog && is_write_op(frame_reg.opcode); // [R3]
    assign recovering = rec_reg != '0;

    always_comb begin
        start_job = 1'b0;
        do_pause = 1'b0;
        do_continue = 1'b0;
        do_reset = 1'b0;
        do_dpd = 1'b0;
        do_wake = 1'b0;
        if (frame_end) begin
            if (deep_power_down) begin
                do_wake = frame_reg.opcode == `SFC_OP_DEV_ID
                    && (frame_reg.over
                    || frame_reg.bits >= `SFC_BITS_OPCODE); // [R22] [R23]
            end else if (!recovering) begin // [R9]
                do_reset = len_single && rst_en_reg
                    && frame_reg.opcode == `SFC_OP_RST;
                do_pause = len_single && state_reg == SFC_RUN
                    && frame_reg.opcode == `SFC_OP_PAUSE; // [R8] [R10]
                if (state_reg == SFC_IDLE || state_reg == SFC_PAUSED) begin
                    start_job = op_erase || op_prog; // [R2] [R11]
                    do_continue = len_single
                        && state_reg == SFC_PAUSED
                        && frame_reg.opcode == `SFC_OP_CONTINUE; // [R14] [R12]
                    do_dpd = len_single
                        && frame_reg.opcode == `SFC_OP_DEEP_PD; // [R21]
                end
            end
        end
    end

    // Reset enable must be the frame just before the reset opcode.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rst_en_reg <= 1'b0;
        end else if (frame_end && !deep_power_down && !recovering) begin
            rst_en_reg <= len_single
                && frame_reg.opcode == `SFC_OP_RST_EN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operation sequencer.

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SFC_IDLE: begin
                if (start_job) begin
                    state_next = SFC_RUN; // [R2]
                end
            end
            SFC_RUN: begin
                if (do_reset) begin
                    state_next = SFC_IDLE;
                end else if (do_pause) begin
                    state_next = SFC_PAUSED; // [R8]
                end else if (timer_reg == cyc(1)) begin
                    state_next = job_reg == SFC_JOB_PROG ? SFC_FLUSH
                        : SFC_IDLE; // [R2]
                end
            end
            SFC_PAUSED: begin
                if (do_reset) begin
                    state_next = SFC_IDLE; // [R13] [R15]
                end else if (start_job) begin
                    state_next = SFC_RUN; // [R11] [R15]
                end else if (do_continue) begin
                    state_next = SFC_RUN; // [R14]
                end
            end
            SFC_FLUSH: begin
                if (do_reset || flush_idx_reg == 8'hFF) begin
                    state_next = SFC_IDLE;
                end
            end
            default: begin
                state_next = SFC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_reg <= SFC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Job capture and timer; the timer holds its count while paused.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            job_reg <= SFC_JOB_ERASE;
            timer_reg <= '0;
            page_reg <= 12'h000;
            low_current_active <= 1'b0;
        end else if (start_job) begin
            job_reg <= op_erase ? SFC_JOB_ERASE : SFC_JOB_PROG;
            page_reg <= frame_reg.addr[19:8]; // [R4]
            low_current_active <= op_prog
                && frame_reg.opcode == `SFC_OP_PROG_LOW; // [R3]
            timer_reg <= op_erase ? cyc(ERASE_CYC)
                : frame_reg.opcode == `SFC_OP_PROG_LOW ? cyc(PROG_LOW_CYC)
                : cyc(PROG_CYC); // [R3]
        end else if (do_reset) begin
            timer_reg <= '0;
            low_current_active <= 1'b0;
        end else if (state_reg == SFC_RUN && timer_reg != '0) begin
            timer_reg <= timer_reg - cyc(1); // [R2]
        end else if (state_reg == SFC_IDLE) begin
            low_current_active <= 1'b0;
        end
    end

    // Recovery window after a pause, during which commands are refused.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rec_reg <= '0;
        end else if (do_pause) begin
            rec_reg <= PAUSE_CYC; // [R8] [R9]
        end else if (recovering) begin
            rec_reg <= rec_reg - cyc(1);
        end
    end

    // Array writes: erase pulse at erase end, valid bytes during flush.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            flush_idx_reg <= 8'h00;
            array_erase_all <= 1'b0;
            array_wr_en <= 1'b0;
            array_wr_addr <= 20'h00000;
            array_wr_data <= 8'h00;
        end else begin
            array_erase_all <= state_reg == SFC_RUN && !do_pause
                && !do_reset && job_reg == SFC_JOB_ERASE
                && timer_reg == cyc(1); // [R1]
            array_wr_en <= state_reg == SFC_FLUSH && !do_reset
                && buf_valid_reg[flush_idx_reg]; // [R7]
            array_wr_addr <= {page_reg, flush_idx_reg}; // [R4]
            array_wr_data <= page_buf[flush_idx_reg];
            if (state_reg == SFC_FLUSH) begin
                flush_idx_reg <= flush_idx_reg + 8'h01;
            end else begin
                flush_idx_reg <= 8'h00;
            end
        end
    end

    // Status flags.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            busy <= 1'b0;
            paused_flag <= 1'b0;
        end else begin
            busy <= state_next == SFC_RUN || state_next == SFC_FLUSH
                || state_reg == SFC_RUN || state_reg == SFC_FLUSH // [R2]
                || do_pause || (recovering && rec_reg != cyc(1)); // [R9]
            paused_flag <= state_next == SFC_PAUSED; // [R14]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            deep_power_down <= 1'b0;
        end else if (do_dpd) begin
            deep_power_down <= 1'b1; // [R21]
        end else if (do_wake) begin
            deep_power_down <= 1'b0; // [R23]
        end
    end

endmodule : sfc_core

`default_nettype wire

// File: include/sfc_defines.svh
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH

// Opcodes.
`define SFC_OP_ERASE_A 8'h60
`define SFC_OP_ERASE_B 8'hC7
`define SFC_OP_PROG 8'h02
`define SFC_OP_PROG_LOW 8'h0A
`define SFC_OP_PAUSE 8'hB0
`define SFC_OP_CONTINUE 8'h30
`define SFC_OP_STD_ID 8'h9F
`define SFC_OP_DEV_ID 8'hAB
`define SFC_OP_DEEP_PD 8'hB9
`define SFC_OP_RST_EN 8'h66
`define SFC_OP_RST 8'h99

// Frame bit counts.
`define SFC_BITS_OPCODE 16'h0008
`define SFC_BITS_ADDR_END 16'h0020
`define SFC_BITS_DATA_START 16'h0028
`define SFC_BITS_STD_ID_END 16'h0028
`define SFC_BITS_DEV_ID_START 16'h0020

// Identification values, arbitrary neutral codes.
`define SFC_ID_MAKER 8'hA5
`define SFC_ID_TYPE 8'h5A
`define SFC_ID_CAPACITY 8'h3C
`define SFC_ID_RESERVED 8'h00
`define SFC_ID_DEVICE 8'hC3

// Timing.
`define SFC_CLK_MHZ 25
`define SFC_T_PAUSE_US 20
`define SFC_PAUSE_CYC (`SFC_T_PAUSE_US * `SFC_CLK_MHZ)
`define SFC_ERASE_CYC_DEF 100000
`define SFC_PROG_CYC_DEF 10000
`define SFC_PROG_LOW_CYC_DEF 20000
`define SFC_TIMER_W 24

`endif

// File: include/sfc_pkg.sv
`default_nettype none

package sfc_pkg;

    typedef enum logic [3:0] {
        SFC_IDLE = 4'h1,
        SFC_RUN = 4'h2,
        SFC_PAUSED = 4'h4,
        SFC_FLUSH = 4'h8
    } sfc_state_t;

    typedef enum logic [1:0] {
        SFC_JOB_ERASE = 2'h1,
        SFC_JOB_PROG = 2'h2
    } sfc_job_t;

    typedef struct packed {
        logic over;
        logic [15:0] bits;
        logic [7:0] opcode;
        logic [23:0] addr;
    } sfc_frame_t;

endpackage : sfc_pkg

`default_nettype wire

// File: testbench/sfc_core_properties.sv
`default_nettype none

module sfc_core_properties #(
    parameter int ERASE_CYC = 20,
    parameter int PROG_CYC = 10,
    parameter int PROG_LOW_CYC = 15
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic spi_cs_n,
    input wire logic spi_so_oe,
    input wire logic busy,
    input wire logic paused_flag,
    input wire logic deep_power_down,
    input wire logic low_current_active,
    input wire logic array_erase_all,
    input wire logic array_wr_en,
    input wire logic [19:0] array_wr_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_oe_deselected: assert property (spi_cs_n |-> !spi_so_oe)
        else $error("serial output driven while deselected");
    a_id_not_busy: assert property (spi_so_oe |-> !busy)
        else $error("identity output during a write");
    a_busy_after_frame: assert property (
        $rose(busy) |-> $past(spi_cs_n, 2))
        else $error("busy rose inside a frame");
    a_erase_ends_busy: assert property (
        array_erase_all |-> busy ##1 !busy)
        else $error("erase pulse not at end of busy");
    a_write_in_busy: assert property (
        array_wr_en |-> busy && !paused_flag)
        else $error("array write outside a running job");
    a_column_ascends: assert property (
        array_wr_en && $past(array_wr_en) |->
        array_wr_addr == $past(array_wr_addr) + 20'h00001)
        else $error("program columns not ascending in page");
    a_pause_from_run: assert property (
        $rose(paused_flag) |-> $past(busy))
        else $error("pause entered without a running job");
    a_dpd_not_busy: assert property (deep_power_down |-> !busy)
        else $error("busy while in deep power-down");
    a_low_current_job: assert property (
        low_current_active |-> busy || paused_flag)
        else $error("low-current flag without a job");
endmodule : sfc_core_properties

bind sfc_core sfc_core_properties #(
    .ERASE_CYC(ERASE_CYC),
    .PROG_CYC(PROG_CYC),
    .PROG_LOW_CYC(PROG_LOW_CYC)
) u_sfc_core_properties (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .spi_cs_n(spi_cs_n),
    .spi_so_oe(spi_so_oe),
    .busy(busy),
    .paused_flag(paused_flag),
    .deep_power_down(deep_power_down),
    .low_current_active(low_current_active),
    .array_erase_all(array_erase_all),
    .array_wr_en(array_wr_en),
    .array_wr_addr(array_wr_addr)
);

`default_nettype wire

// File: testbench/sfc_host_model.sv
`default_nettype none

module sfc_host_model (
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_si,
    input wire logic spi_so_line
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] tx [0:299];
    logic [7:0] rx [0:299];

    initial begin
        spi_sck = 1'b0;
        spi_si = 1'b0;
        spi_cs_n = 1'b0;
        #1;
        spi_cs_n = 1'b1; // A clean rise clears the link logic before use.
    end

    // Mode 0 frame; the clock stands still outside frames.
    task automatic xfer(input int nbits);
        int i;
        spi_cs_n = 1'b0;
        for (i = 0; i < nbits; i++) begin
            spi_si = tx[i / 8][7 - i % 8];
            #3;
            spi_sck = 1'b1;
            rx[i / 8][7 - i % 8] = spi_so_line;
            #3;
            spi_sck = 1'b0;
        end
        #3;
        spi_cs_n = 1'b1;
        spi_si = ~spi_si;
    endtask : xfer
endmodule : sfc_host_model

`default_nettype wire

// File: testbench/tb_top.sv
`include "sfc_defines.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe, so_line = 1'b0;
    logic busy, paused_flag, deep_power_down, low_current_active;
    logic array_erase_all, array_wr_en, oe_seen;
    logic [19:0] array_wr_addr, last_addr;
    logic [7:0] array_wr_data, first_data, last_data;
    int mismatches = 0, checks_done = 0, cycles = 0, erase_cnt = 0, wr_cnt;

    always #20 clk_sys = ~clk_sys;

    sfc_core #(.ERASE_CYC(200), .PROG_CYC(10), .PROG_LOW_CYC(15)) u_sfc_core (
        .clk_sys(clk_sys), .resetn(resetn), .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so),
        .spi_so_oe(spi_so_oe), .busy(busy), .paused_flag(paused_flag),
        .deep_power_down(deep_power_down),
        .low_current_active(low_current_active),
        .array_erase_all(array_erase_all), .array_wr_en(array_wr_en),
        .array_wr_addr(array_wr_addr), .array_wr_data(array_wr_data));

    sfc_host_model u_sfc_host_model (.spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so_line(so_line));

    // A released line shows the inverse of its last level.
    always @(spi_so or spi_so_oe) so_line = spi_so_oe ? spi_so : ~so_line;
    always @(posedge spi_sck) if (spi_so_oe === 1'b1) oe_seen = 1'b1;

    always @(posedge clk_sys) begin
        cycles++;
        if (array_erase_all === 1'b1) erase_cnt++;
        if (array_wr_en === 1'b1) begin
            if (wr_cnt == 0) first_data = array_wr_data;
            wr_cnt++;
            last_addr = array_wr_addr;
            last_data = array_wr_data;
        end
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic send(input int nbits);
        @(negedge clk_sys);
        u_sfc_host_model.xfer(nbits);
        repeat (6) @(negedge clk_sys);
    endtask : send

    task automatic cmd(input logic [7:0] op);
        u_sfc_host_model.tx[0] = op;
        send(8);
    endtask : cmd

    task automatic wait_idle;
        int k;
        for (k = 0; k < 3000 && busy !== 1'b0; k++) @(negedge clk_sys);
        check(busy, 0);
    endtask : wait_idle

    task automatic load(input logic [31:0] hdr);
        {u_sfc_host_model.tx[0], u_sfc_host_model.tx[1]} = hdr[31:16];
        {u_sfc_host_model.tx[2], u_sfc_host_model.tx[3]} = hdr[15:0];
        wr_cnt = 0;
    endtask : load

    ////////////////////////////////////////////////////////////////////////
    task automatic t_erase;
        int e = erase_cnt;
        u_sfc_host_model.tx[0] = 8'h60;
        send(7);
        check(busy, 0);
        cmd(8'h60);
        check(busy, 1);
        wait_idle();
        cmd(8'hC7);
        wait_idle();
        check(erase_cnt, e + 2);
    endtask : t_erase

    task automatic t_program(input logic [7:0] op, input logic lowc);
        load({op, 24'h0123FE});
        {u_sfc_host_model.tx[4], u_sfc_host_model.tx[5]} = 16'h1122;
        u_sfc_host_model.tx[6] = 8'h33;
        send(56);
        check(low_current_active, lowc);
        wait_idle();
        check(wr_cnt, 3);
        check({last_addr, last_data}, 28'h123FF22);
        check(first_data, 8'h33);
    endtask : t_program

    task automatic t_overflow;
        int i;
        load(32'h02000000);
        for (i = 0; i < 258; i++) begin
            u_sfc_host_model.tx[4 + i] = (i < 256) ? i[7:0] : 8'hDE + i[7:0];
        end
        send(2096);
        wait_idle();
        check(wr_cnt, 256);
        check({first_data, last_data}, 16'hDEFF);
        send(41);
        check(busy, 0);
    endtask : t_overflow

    task automatic pause_job;
        cmd(8'h60);
        cmd(8'hB0);
        repeat (500) @(negedge clk_sys);
        check({busy, paused_flag}, 2'h1);
    endtask : pause_job

    task automatic t_pause;
        int e;
        cmd(8'hB0);
        check(paused_flag, 0);
        cmd(8'h60);
        cmd(8'hB0);
        check(busy, 1);
        cmd(8'h60);
        repeat (500) @(negedge clk_sys);
        check({busy, paused_flag}, 2'h1);
        e = erase_cnt;
        cmd(8'h30);
        check({busy, paused_flag}, 2'h2);
        wait_idle(); // Gap before the next pause.
        check(erase_cnt, e + 1);
        pause_job();
        load(32'h02012300);
        u_sfc_host_model.tx[4] = 8'h5A;
        send(40);
        check(paused_flag, 0);
        wait_idle();
        cmd(8'h30);
        check(busy, 0);
        pause_job();
        cmd(8'h66);
        cmd(8'h99);
        check(paused_flag, 0);
        cmd(8'h30);
        check(busy, 0);
    endtask : t_pause

    task automatic t_ids;
        u_sfc_host_model.tx[0] = 8'h9F;
        send(40);
        check({u_sfc_host_model.rx[1], u_sfc_host_model.rx[2],
               u_sfc_host_model.rx[3], u_sfc_host_model.rx[4]},
              {`SFC_ID_MAKER, `SFC_ID_TYPE, `SFC_ID_CAPACITY,
               `SFC_ID_RESERVED});
        u_sfc_host_model.tx[0] = 8'hAB;
        send(48);
        check({u_sfc_host_model.rx[4], u_sfc_host_model.rx[5]},
              {2{`SFC_ID_DEVICE}});
        check(spi_so_oe, 0);
        cmd(8'h60);
        oe_seen = 1'b0;
        u_sfc_host_model.tx[0] = 8'h9F;
        send(40);
        check(oe_seen, 0);
        wait_idle();
    endtask : t_ids

    task automatic t_deep;
        cmd(8'h60);
        cmd(8'hB9);
        check(deep_power_down, 0);
        wait_idle();
        cmd(8'hB9);
        check(deep_power_down, 1);
        cmd(8'h60);
        check(busy, 0);
        cmd(8'hAB);
        check(deep_power_down, 0);
        cmd(8'hB9);
        u_sfc_host_model.tx[0] = 8'hAB;
        send(48);
        check({deep_power_down, u_sfc_host_model.rx[4]},
              {1'b0, `SFC_ID_DEVICE});
    endtask : t_deep

    initial begin
        repeat (20) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (4) @(negedge clk_sys);
        t_erase(); // Array blanked before any programming.
        t_program(8'h02, 1'b0);
        t_program(8'h0A, 1'b1);
        t_overflow();
        t_pause();
        t_ids();
        t_deep();
        stop_test();
    end
endmodule : tb_top

`default_nettype wire
